// >>> shared/ccic_consts.svh
// named constants for the carry/clear/invert/compare execution unit
`ifndef CCIC_CONSTS_SVH
`define CCIC_CONSTS_SVH

// opcodes
`define CCIC_OP_INV_CARRY   8'hEF
`define CCIC_OP_ZERO_R      8'h80
`define CCIC_OP_ZERO_PTR    8'h81
`define CCIC_OP_NOT_R       8'h60
`define CCIC_OP_NOT_PTR     8'h61
`define CCIC_OP_DADJ_R      8'h40
`define CCIC_OP_DADJ_PTR    8'h41
`define CCIC_OP_CMP_WW      8'hA2
`define CCIC_OP_CMP_WIW     8'hA3
`define CCIC_OP_CMP_RR      8'hA4
`define CCIC_OP_CMP_RIR     8'hA5
`define CCIC_OP_CMP_RIM     8'hA6
`define CCIC_OP_CMP_IRIM    8'hA7

// cycle counts per instruction
`define CCIC_CYC_SHORT      4'h6
`define CCIC_CYC_DADJ       4'h8
`define CCIC_CYC_LONG       4'hA
`define CCIC_CNT_ONE        4'h1

// working register selection
`define CCIC_WREG_PREFIX    4'hE

// flag bit positions inside the flag byte, then sign and borrow bit positions of the result
`define CCIC_FLAG_C         7
`define CCIC_FLAG_Z         6
`define CCIC_FLAG_S         5
`define CCIC_FLAG_V         4
`define CCIC_FLAG_D         3
`define CCIC_FLAG_H         2
`define CCIC_SIGN_BIT       7
`define CCIC_BORROW_BIT     8

// values
`define CCIC_FLAGS_RST      8'h00
`define CCIC_WRP_RST        8'h00
`define CCIC_REG_RST        8'h00
`define CCIC_CLEAR_VAL      8'h00
`define CCIC_ZERO_BYTE      8'h00
`define CCIC_DADJ_LOW_FIX   8'h06
`define CCIC_DADJ_HIGH_FIX  8'h60
`define CCIC_DADJ_NIB_MAX   4'h9
`define CCIC_DADJ_BYTE_MAX  8'h99

// register bus map
`define CCIC_ADDR_FLAGS     9'h100
`define CCIC_ADDR_WRP       9'h101
`define CCIC_ADDR_STATUS    9'h102
`define CCIC_BUS_CTRL_BIT   8

`endif

// >>> shared/ccic_pkg.sv
// types for the carry/clear/invert/compare execution unit
package ccic_pkg;

   typedef enum logic [1:0]
   {
      CCIC_IDLE = 2'h0,
      CCIC_ADDR = 2'h1,
      CCIC_OPER = 2'h3,
      CCIC_WAIT = 2'h2
   } ccic_state_type;

   typedef enum logic [2:0]
   {
      CCIC_K_NONE = 3'h0,
      CCIC_K_INVC = 3'h1,
      CCIC_K_ZERO = 3'h2,
      CCIC_K_NOT  = 3'h3,
      CCIC_K_DADJ = 3'h4,
      CCIC_K_CMP  = 3'h5
   } ccic_kind_type;

endpackage

// >>> shared/ccic_rf_if.sv
// register file ports shared between execution core and storage
interface ccic_rf_if;
   logic [7:0] ra_addr;
   logic [7:0] ra_data;
   logic [7:0] rb_addr;
   logic [7:0] rb_data;
   logic [7:0] rc_addr;
   logic [7:0] rc_data;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   modport core  (output ra_addr, rb_addr, rc_addr, wr_en, wr_addr, wr_data,
                  input  ra_data, rb_data, rc_data);
   modport store (input  ra_addr, rb_addr, rc_addr, wr_en, wr_addr, wr_data,
                  output ra_data, rb_data, rc_data);
endinterface

// >>> design/ccic_regfile.sv
// 256 byte register file, three read ports and one write port
`include "ccic_consts.svh"

module ccic_regfile
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  ce_i,
   ccic_rf_if.store   rf
);

   logic [7:0] mem_ff [256];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 256; i++)
         begin
            mem_ff[i] <= `CCIC_REG_RST;
         end
      end
      else if (ce_i && rf.wr_en)
      begin
         mem_ff[rf.wr_addr] <= rf.wr_data;
      end
   end

   // reads are combinational so indirection resolves in one cycle
   assign rf.ra_data = mem_ff[rf.ra_addr];
   assign rf.rb_data = mem_ff[rf.rb_addr];
   assign rf.rc_data = mem_ff[rf.rc_addr];

endmodule // ccic_regfile

// >>> design/ccic_core.sv
// execution core for carry invert, clear, invert, compare and decimal adjust
//
// Functional notes
// - carry invert: 6 cycles, only carry toggles
// - clear writes 00h, flags kept, 6 cycles
// - upper nibble 1110b selects working register
// - invert replaces destination with complement, 6 cycles
// - invert: zero, sign from result, overflow cleared
// - compare subtracts; 6 or 10 cycles by opcode
// - compare writes no operand, flags only
// - compare carry set on borrow
// - compare zero, sign, overflow from difference
// - decimal adjust corrects byte to packed BCD
//
// Local design decisions: the plain strobed port and the register offsets.
`include "ccic_consts.svh"

module ccic_core
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        start_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  arg1_i,
   input  wire logic [7:0]  arg2_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             bad_op_o,
   output logic [7:0]       flags_o,
   input  wire logic [8:0]  bus_addr_i,
   input  wire logic [7:0]  bus_wdata_i,
   input  wire logic        bus_we_i,
   input  wire logic        bus_re_i,
   output logic [7:0]       bus_rdata_o
);

   ccic_rf_if rf ();

   ccic_regfile u_regfile
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .rf    (rf.store)
   );

   function automatic logic [7:0] resolve(input logic [7:0] field, input logic [7:0] wrp);
      if (field[7:4] == `CCIC_WREG_PREFIX)
         return {wrp[7:4], field[3:0]};
      return field;
   endfunction

   function automatic ccic_pkg::ccic_kind_type kind_of(input logic [7:0] op);
      case (op)
         `CCIC_OP_INV_CARRY:                 return ccic_pkg::CCIC_K_INVC;
         `CCIC_OP_ZERO_R, `CCIC_OP_ZERO_PTR: return ccic_pkg::CCIC_K_ZERO;
         `CCIC_OP_NOT_R, `CCIC_OP_NOT_PTR:   return ccic_pkg::CCIC_K_NOT;
         `CCIC_OP_DADJ_R, `CCIC_OP_DADJ_PTR: return ccic_pkg::CCIC_K_DADJ;
         `CCIC_OP_CMP_WW, `CCIC_OP_CMP_WIW, `CCIC_OP_CMP_RR,
         `CCIC_OP_CMP_RIR, `CCIC_OP_CMP_RIM,
         `CCIC_OP_CMP_IRIM:                  return ccic_pkg::CCIC_K_CMP;
         default:                            return ccic_pkg::CCIC_K_NONE;
      endcase
   endfunction

   function automatic logic [3:0] cycles_of(input logic [7:0] op);
      case (op)
         `CCIC_OP_DADJ_R, `CCIC_OP_DADJ_PTR:                 return `CCIC_CYC_DADJ;
         `CCIC_OP_CMP_RR, `CCIC_OP_CMP_RIR, `CCIC_OP_CMP_RIM,
         `CCIC_OP_CMP_IRIM:                                 return `CCIC_CYC_LONG;
         default:                                           return `CCIC_CYC_SHORT;
      endcase
   endfunction

   ccic_pkg::ccic_state_type state_ff;
   ccic_pkg::ccic_state_type nxt_state;
   ccic_pkg::ccic_kind_type  kind_ff;
   logic [7:0] op_ff;
   logic [7:0] a1_ff;
   logic [7:0] a2_ff;
   logic [3:0] cyc_ff;
   logic [3:0] cnt_ff;
   logic [7:0] flags_ff;
   logic [7:0] wrp_ff;
   logic [7:0] dst_addr_ff;
   logic [7:0] src_addr_ff;
   logic [7:0] dst_val_ff;
   logic [7:0] src_val_ff;

   logic       accept;
   logic       commit;
   logic       idle;
   logic [7:0] dfield;
   logic [7:0] sfield;
   logic       dind;
   logic       sind;
   logic       simm;

   assign idle   = (state_ff == ccic_pkg::CCIC_IDLE);
   assign accept = idle && start_i && (kind_of(opcode_i) != ccic_pkg::CCIC_K_NONE);
   assign commit = (state_ff == ccic_pkg::CCIC_WAIT) && (cnt_ff == cyc_ff - `CCIC_CNT_ONE);
   assign busy_o = !idle;

   // operand fields per addressing form; r forms reuse the prefix path
   always_comb
   begin
      dfield = a1_ff;
      sfield = a2_ff;
      dind   = 1'b0;
      sind   = 1'b0;
      simm   = 1'b0;
      case (op_ff)
         `CCIC_OP_ZERO_PTR, `CCIC_OP_NOT_PTR, `CCIC_OP_DADJ_PTR:
            dind = 1'b1;
         `CCIC_OP_CMP_WW, `CCIC_OP_CMP_WIW:
         begin
            dfield = {`CCIC_WREG_PREFIX, a1_ff[7:4]};
            sfield = {`CCIC_WREG_PREFIX, a1_ff[3:0]};
            sind   = (op_ff == `CCIC_OP_CMP_WIW);
         end
         `CCIC_OP_CMP_RR, `CCIC_OP_CMP_RIR:
         begin
            dfield = a2_ff;
            sfield = a1_ff;
            sind   = (op_ff == `CCIC_OP_CMP_RIR);
         end
         `CCIC_OP_CMP_RIM:
            simm = 1'b1;
         `CCIC_OP_CMP_IRIM:
         begin
            dind = 1'b1;
            simm = 1'b1;
         end
         default:
            dind = 1'b0;
      endcase
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ccic_pkg::CCIC_IDLE: if (accept) nxt_state = ccic_pkg::CCIC_ADDR;
         ccic_pkg::CCIC_ADDR: nxt_state = ccic_pkg::CCIC_OPER;
         ccic_pkg::CCIC_OPER: nxt_state = ccic_pkg::CCIC_WAIT;
         ccic_pkg::CCIC_WAIT: if (commit) nxt_state = ccic_pkg::CCIC_IDLE;
         default:             nxt_state = ccic_pkg::CCIC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_ff <= ccic_pkg::CCIC_IDLE;
      else if (ce_i)
         state_ff <= nxt_state;
   end

   // instruction latch and cycle counter; cycle 0 is the accepting cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         kind_ff <= ccic_pkg::CCIC_K_NONE;
         op_ff   <= `CCIC_ZERO_BYTE;
         a1_ff   <= `CCIC_ZERO_BYTE;
         a2_ff   <= `CCIC_ZERO_BYTE;
         cyc_ff  <= `CCIC_CYC_SHORT;
         cnt_ff  <= `CCIC_CNT_ONE;
      end
      else if (ce_i)
      begin
         if (accept)
         begin
            kind_ff <= kind_of(opcode_i);
            op_ff   <= opcode_i;
            a1_ff   <= arg1_i;
            a2_ff   <= arg2_i;
            cyc_ff  <= cycles_of(opcode_i);
            cnt_ff  <= `CCIC_CNT_ONE;
         end
         else if (!idle)
            cnt_ff  <= cnt_ff + `CCIC_CNT_ONE;
      end
   end

   // operand address resolution, then operand fetch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dst_addr_ff <= `CCIC_ZERO_BYTE;
         src_addr_ff <= `CCIC_ZERO_BYTE;
         dst_val_ff  <= `CCIC_ZERO_BYTE;
         src_val_ff  <= `CCIC_ZERO_BYTE;
      end
      else if (ce_i)
      begin
         if (state_ff == ccic_pkg::CCIC_ADDR)
         begin
            dst_addr_ff <= dind ? rf.ra_data : resolve(dfield, wrp_ff);
            src_addr_ff <= sind ? rf.rb_data : resolve(sfield, wrp_ff);
         end
         if (state_ff == ccic_pkg::CCIC_OPER)
         begin
            dst_val_ff <= rf.ra_data;
            src_val_ff <= simm ? a2_ff : rf.rb_data;
         end
      end
   end

   assign rf.ra_addr = (state_ff == ccic_pkg::CCIC_ADDR) ? resolve(dfield, wrp_ff) : dst_addr_ff;
   assign rf.rb_addr = (state_ff == ccic_pkg::CCIC_ADDR) ? resolve(sfield, wrp_ff) : src_addr_ff;
   assign rf.rc_addr = bus_addr_i[7:0];

   // arithmetic
   logic [8:0] diff9;
   logic [7:0] diff;
   logic [7:0] not_res;
   logic [7:0] adj_res;
   logic       adj_c;
   logic [7:0] adj_fix;

   always_comb
   begin
      diff9   = {1'b0, dst_val_ff} - {1'b0, src_val_ff};
      diff    = diff9[7:0];
      not_res = ~dst_val_ff;
      adj_fix = `CCIC_ZERO_BYTE;
      if (!flags_ff[`CCIC_FLAG_D])
      begin
         if (flags_ff[`CCIC_FLAG_H] || (dst_val_ff[3:0] > `CCIC_DADJ_NIB_MAX))
            adj_fix = adj_fix | `CCIC_DADJ_LOW_FIX;
         if (flags_ff[`CCIC_FLAG_C] || (dst_val_ff > `CCIC_DADJ_BYTE_MAX))
            adj_fix = adj_fix | `CCIC_DADJ_HIGH_FIX;
         adj_res = dst_val_ff + adj_fix;
         adj_c   = flags_ff[`CCIC_FLAG_C] || (dst_val_ff > `CCIC_DADJ_BYTE_MAX);
      end
      else
      begin
         // after a subtract only the flags say which digit borrowed
         if (flags_ff[`CCIC_FLAG_H])
            adj_fix = adj_fix | `CCIC_DADJ_LOW_FIX;
         if (flags_ff[`CCIC_FLAG_C])
            adj_fix = adj_fix | `CCIC_DADJ_HIGH_FIX;
         adj_res = dst_val_ff - adj_fix;
         adj_c   = flags_ff[`CCIC_FLAG_C];
      end
   end

   // write port: commit has the port, bus writes only land while idle
   always_comb
   begin
      rf.wr_en   = 1'b0;
      rf.wr_addr = bus_addr_i[7:0];
      rf.wr_data = bus_wdata_i;
      if (commit)
      begin
         rf.wr_addr = dst_addr_ff;
         case (kind_ff)
            ccic_pkg::CCIC_K_ZERO:
            begin
               rf.wr_en   = 1'b1;
               rf.wr_data = `CCIC_CLEAR_VAL;
            end
            ccic_pkg::CCIC_K_NOT:
            begin
               rf.wr_en   = 1'b1;
               rf.wr_data = not_res;
            end
            ccic_pkg::CCIC_K_DADJ:
            begin
               rf.wr_en   = 1'b1;
               rf.wr_data = adj_res;
            end
            default:
               rf.wr_en = 1'b0;
         endcase
      end
      else if (idle && bus_we_i && !bus_addr_i[`CCIC_BUS_CTRL_BIT])
         rf.wr_en = 1'b1;
   end

   // flag byte
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flags_ff <= `CCIC_FLAGS_RST;
      else if (ce_i)
      begin
         if (commit)
         begin
            case (kind_ff)
               ccic_pkg::CCIC_K_INVC:
                  flags_ff[`CCIC_FLAG_C] <= ~flags_ff[`CCIC_FLAG_C];
               ccic_pkg::CCIC_K_NOT:
               begin
                  flags_ff[`CCIC_FLAG_Z] <= (not_res == `CCIC_ZERO_BYTE);
                  flags_ff[`CCIC_FLAG_S] <= not_res[`CCIC_SIGN_BIT];
                  flags_ff[`CCIC_FLAG_V] <= 1'b0;
               end
               ccic_pkg::CCIC_K_CMP:
               begin
                  flags_ff[`CCIC_FLAG_C] <= diff9[`CCIC_BORROW_BIT];
                  flags_ff[`CCIC_FLAG_Z] <= (diff == `CCIC_ZERO_BYTE);
                  flags_ff[`CCIC_FLAG_S] <= diff[`CCIC_SIGN_BIT];
                  flags_ff[`CCIC_FLAG_V] <= (dst_val_ff[`CCIC_SIGN_BIT] ^ src_val_ff[`CCIC_SIGN_BIT])
                                          & (diff[`CCIC_SIGN_BIT] ^ dst_val_ff[`CCIC_SIGN_BIT]);
               end
               ccic_pkg::CCIC_K_DADJ:
               begin
                  // overflow is left as is: its value is undefined here
                  flags_ff[`CCIC_FLAG_C] <= adj_c;
                  flags_ff[`CCIC_FLAG_Z] <= (adj_res == `CCIC_ZERO_BYTE);
                  flags_ff[`CCIC_FLAG_S] <= adj_res[`CCIC_SIGN_BIT];
               end
               default:
                  flags_ff <= flags_ff;
            endcase
         end
         else if (idle && bus_we_i && (bus_addr_i == `CCIC_ADDR_FLAGS))
            flags_ff <= bus_wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wrp_ff <= `CCIC_WRP_RST;
      else if (ce_i && idle && bus_we_i && (bus_addr_i == `CCIC_ADDR_WRP))
         wrp_ff <= bus_wdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_o   <= 1'b0;
         bad_op_o <= 1'b0;
      end
      else if (ce_i)
      begin
         done_o   <= commit;
         bad_op_o <= idle && start_i && !accept;
      end
   end

   assign flags_o = flags_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_rdata_o <= `CCIC_ZERO_BYTE;
      else if (ce_i)
      begin
         if (!bus_re_i)
            bus_rdata_o <= `CCIC_ZERO_BYTE;
         else if (!bus_addr_i[`CCIC_BUS_CTRL_BIT])
            bus_rdata_o <= rf.rc_data;
         else if (bus_addr_i == `CCIC_ADDR_FLAGS)
            bus_rdata_o <= flags_ff;
         else if (bus_addr_i == `CCIC_ADDR_WRP)
            bus_rdata_o <= wrp_ff;
         else if (bus_addr_i == `CCIC_ADDR_STATUS)
            bus_rdata_o <= {7'h00, busy_o};
         else
            bus_rdata_o <= `CCIC_ZERO_BYTE;
      end
   end

endmodule // ccic_core

// >>> testbench/ccic_core_chk.sv
// concurrent checks on the execution core ports
module ccic_chk
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic       start_i,
   input wire logic [7:0] opcode_i,
   input wire logic [7:0] arg1_i,
   input wire logic [7:0] arg2_i,
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic       bad_op_o,
   input wire logic [7:0] flags_o,
   input wire logic [8:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic       bus_we_i,
   input wire logic       bus_re_i,
   input wire logic [7:0] bus_rdata_o
);
   logic go;
   logic short_go;
   logic long_go;
   logic adj_go;

   default clocking chk_cb @(posedge clk_i);
   endclocking
   // timing counts assume a running clock enable; a freeze drops open attempts
   default disable iff (rst_i || !ce_i);

   assign go       = start_i && ce_i && !busy_o;
   assign short_go = go && (opcode_i inside {8'hEF, 8'h80, 8'h81, 8'h60, 8'h61, 8'hA2, 8'hA3});
   assign long_go  = go && (opcode_i inside {[8'hA4:8'hA7]});
   assign adj_go   = go && (opcode_i inside {8'h40, 8'h41});

   short_time_a:
   assert property (short_go |=> busy_o[*5] ##1 (done_o && !busy_o))
      else $error("short instruction timing wrong");
   long_time_a:
   assert property (long_go |=> busy_o[*8] ##1 busy_o ##1 (done_o && !busy_o))
      else $error("long compare timing wrong");
   adjust_time_a:
   assert property (adj_go |=> busy_o[*7] ##1 (done_o && !busy_o))
      else $error("decimal adjust timing wrong");
   carry_flip_a:
   assert property (go && opcode_i == 8'hEF |-> ##6 (flags_o[7] != $past(flags_o[7], 6))
                    && (flags_o[6:2] == $past(flags_o[6:2], 6)))
      else $error("carry invert flags wrong");
   clear_flags_a:
   assert property (go && opcode_i inside {8'h80, 8'h81} |-> ##6 flags_o == $past(flags_o, 6))
      else $error("clear changed flags");
   invert_flags_a:
   assert property (go && opcode_i inside {8'h60, 8'h61} |-> ##6 !flags_o[4]
                    && flags_o[7] == $past(flags_o[7], 6) && flags_o[3:2] == $past(flags_o[3:2], 6))
      else $error("invert flags wrong");
   cmp_dh_short_a:
   assert property (go && opcode_i inside {8'hA2, 8'hA3} |-> ##6
                    flags_o[3:2] == $past(flags_o[3:2], 6))
      else $error("short compare touched d or h");
   cmp_dh_long_a:
   assert property (long_go |-> ##10 flags_o[3:2] == $past(flags_o[3:2], 10))
      else $error("long compare touched d or h");
   adjust_vdh_a:
   assert property (adj_go |-> ##8 flags_o[4:2] == $past(flags_o[4:2], 8))
      else $error("decimal adjust touched v d or h");
endmodule // ccic_chk

// >>> testbench/test_carry_clear_invert_compare_ops.sv
// self-checking bench for the execution core
module test_carry_clear_invert_compare_ops;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_i       = 1'b0;
   logic       rst_i       = 1'b1;
   logic       ce_i        = 1'b1;
   logic       start_i     = 1'b0;
   logic [7:0] opcode_i    = 8'h00;
   logic [7:0] arg1_i      = 8'h00;
   logic [7:0] arg2_i      = 8'h00;
   logic [8:0] bus_addr_i  = 9'h000;
   logic [7:0] bus_wdata_i = 8'h00;
   logic       bus_we_i    = 1'b0;
   logic       bus_re_i    = 1'b0;
   wire logic       busy_o;
   wire logic       done_o;
   wire logic       bad_op_o;
   wire logic [7:0] flags_o;
   wire logic [7:0] bus_rdata_o;
   int         error_cnt   = 0;
   int         checks_done = 0;
   // operand preload {addr, value}, then compare table {op, a1, a2, n, flags, addr, value}
   logic [15:0] pre_t [12] = '{16'h1316, 16'h1B20, 16'h1F16, 16'h1A20, 16'h2011, 16'h342E,
                               16'h121B, 16'h1601, 16'h4B82, 16'h6C2A, 16'hD4FC, 16'hFC8F};
   logic [55:0] cmp_t [6]  = '{56'hA23B0006AC1316, 56'hA3FA00060C2011, 56'hA412340A0C342E,
                               56'hA5E34B0A2C1601, 56'hA66C2A0A4C6C2A, 56'hA7D47F0A1CFC8F};

   always #5 clk_i = ~clk_i;

   ccic_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i),
                    .opcode_i(opcode_i), .arg1_i(arg1_i), .arg2_i(arg2_i), .busy_o(busy_o),
                    .done_o(done_o), .bad_op_o(bad_op_o), .flags_o(flags_o),
                    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_we_i(bus_we_i),
                    .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o));

   task automatic close_out();
      $display("mismatches %0d of %0d checks", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_we_i    <= 1'b1;
      bus_addr_i  <= a;
      bus_wdata_i <= d;
      @(posedge clk_i);
      bus_we_i    <= 1'b0;
   endtask

   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus_re_i   <= 1'b1;
      bus_addr_i <= a;
      @(posedge clk_i);
      bus_re_i   <= 1'b0;
      #1;
      chk("read data", exp, bus_rdata_o);
   endtask

   // counts cycles from the current one until done, bounded
   task automatic wait_done(output int k);
      k = 0;
      while (done_o !== 1'b1 && k < 20)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k == 20)
      begin
         error_cnt++;
         close_out();
      end
   endtask

   task automatic exec(input logic [7:0] op, a1, a2, n, fl);
      int k;
      @(posedge clk_i);
      start_i  <= 1'b1;
      opcode_i <= op;
      arg1_i   <= a1;
      arg2_i   <= a2;
      @(posedge clk_i);
      start_i  <= 1'b0;
      #1;
      wait_done(k);
      chk("cycle count", n, 8'(k + 1));
      chk("flags", fl, flags_o);
   endtask

   task automatic t_reset();
      chk("flags", 8'h00, flags_o);
      rd(9'h101, 8'h00);
      rd(9'h035, 8'h00);
      wr(9'h1FF, 8'hAA);
      rd(9'h1FF, 8'h00);
      wr(9'h102, 8'hFF);
      rd(9'h102, 8'h00);
   endtask

   task automatic t_carry();
      wr(9'h100, 8'h7C);
      exec(8'hEF, 8'h00, 8'h00, 8'h06, 8'hFC);
      exec(8'hEF, 8'h00, 8'h00, 8'h06, 8'h7C);
   endtask

   task automatic t_clear();
      wr(9'h101, 8'h30);
      wr(9'h035, 8'hAF);
      exec(8'h80, 8'hE5, 8'h00, 8'h06, 8'h7C);
      rd(9'h035, 8'h00);
      wr(9'h0A5, 8'h23);
      wr(9'h023, 8'hFC);
      exec(8'h81, 8'hA5, 8'h00, 8'h06, 8'h7C);
      rd(9'h023, 8'h00);
      rd(9'h0A5, 8'h23);
   endtask

   task automatic t_invert();
      wr(9'h100, 8'h10);
      wr(9'h008, 8'h24);
      exec(8'h60, 8'h08, 8'h00, 8'h06, 8'h20);
      rd(9'h008, 8'hDB);
      wr(9'h100, 8'h9C);
      wr(9'h008, 8'h24);
      wr(9'h024, 8'hFF);
      exec(8'h61, 8'h08, 8'h00, 8'h06, 8'hCC);
      rd(9'h024, 8'h00);
   endtask

   task automatic t_compare();
      wr(9'h101, 8'h10);
      foreach (pre_t[i])
         wr({1'b0, pre_t[i][15:8]}, pre_t[i][7:0]);
      foreach (cmp_t[i])
      begin
         wr(9'h100, 8'h0C);
         exec(cmp_t[i][55:48], cmp_t[i][47:40], cmp_t[i][39:32], cmp_t[i][31:24],
              cmp_t[i][23:16]);
         rd({1'b0, cmp_t[i][15:8]}, cmp_t[i][7:0]);
      end
   endtask

   task automatic t_busy();
      int k;
      wr(9'h077, 8'h55);
      @(posedge clk_i);
      start_i     <= 1'b1;
      opcode_i    <= 8'h80;
      arg1_i      <= 8'h77;
      @(posedge clk_i);
      start_i     <= 1'b0;
      bus_we_i    <= 1'b1;
      bus_addr_i  <= 9'h078;
      bus_wdata_i <= 8'hAA;
      @(posedge clk_i);
      bus_we_i    <= 1'b0;
      bus_re_i    <= 1'b1;
      bus_addr_i  <= 9'h102;
      @(posedge clk_i);
      bus_re_i    <= 1'b0;
      #1;
      chk("status", 8'h01, bus_rdata_o);
      wait_done(k);
      rd(9'h077, 8'h00);
      // the write went to a register the clear never touches, so a leak shows
      rd(9'h078, 8'h00);
      @(posedge clk_i);
      start_i     <= 1'b1;
      opcode_i    <= 8'h00;
      @(posedge clk_i);
      start_i     <= 1'b0;
      #1;
      chk("bad opcode", 8'h01, {7'h00, bad_op_o});
      chk("busy", 8'h00, {7'h00, busy_o});
   endtask

   task automatic t_adjust();
      wr(9'h100, 8'h10);
      wr(9'h05F, 8'h3C);
      exec(8'h40, 8'h5F, 8'h00, 8'h08, 8'h10);
      rd(9'h05F, 8'h42);
      wr(9'h05F, 8'h3C);
      wr(9'h045, 8'h5F);
      exec(8'h41, 8'h45, 8'h00, 8'h08, 8'h10);
      rd(9'h05F, 8'h42);
   endtask

   // execution must stall while the clock enable is low
   task automatic t_freeze();
      int k;
      wr(9'h100, 8'h00);
      @(posedge clk_i);
      start_i  <= 1'b1;
      opcode_i <= 8'hEF;
      @(posedge clk_i);
      start_i  <= 1'b0;
      ce_i     <= 1'b0;
      repeat (8) @(posedge clk_i);
      ce_i     <= 1'b1;
      #1;
      chk("frozen busy", 8'h01, {7'h00, busy_o});
      chk("frozen flags", 8'h00, flags_o);
      wait_done(k);
      chk("cycle count", 8'h06, 8'(k + 1));
      chk("flags", 8'h80, flags_o);
   endtask

   // reset in mid-instruction drops the run and clears all state
   task automatic t_rerun();
      wr(9'h100, 8'hFF);
      @(posedge clk_i);
      start_i  <= 1'b1;
      opcode_i <= 8'h60;
      arg1_i   <= 8'h5F;
      @(posedge clk_i);
      start_i  <= 1'b0;
      rst_i    <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i    <= 1'b0;
      #1;
      chk("busy", 8'h00, {7'h00, busy_o});
      chk("flags", 8'h00, flags_o);
      @(posedge clk_i);
      #1;
      chk("done", 8'h00, {7'h00, done_o});
      rd(9'h05F, 8'h00);
      rd(9'h101, 8'h00);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end

   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_carry();
      t_clear();
      t_invert();
      t_compare();
      t_busy();
      t_adjust();
      t_freeze();
      t_rerun();
      close_out();
   end
endmodule // test_carry_clear_invert_compare_ops

bind ccic_core ccic_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i),
   .opcode_i(opcode_i), .arg1_i(arg1_i), .arg2_i(arg2_i), .busy_o(busy_o), .done_o(done_o),
   .bad_op_o(bad_op_o), .flags_o(flags_o), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
   .bus_we_i(bus_we_i), .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o));
